/* File: bench/pcs_card_model.sv */
// Card-side model: wait, ready, write protect, read acknowledge and sense lines
`timescale 1ns/100ps
module pcs_card_model (
    input wire logic clk,
    input wire logic [3:0] strobes_n,
    input wire logic [3:0] wait_len,
    input wire logic busy,
    input wire logic wp_sw,
    input wire logic dma_rq,
    input wire logic [1:0] volt,
    output logic wait_n,
    output logic ready_in,
    output logic wp_in,
    output logic io_read_ack_n,
    output logic volt_sense_a,
    output logic volt_sense_b
);
    logic act_q = 1'b0;
    logic [3:0] cnt_q = 4'h0;
    // Wait goes active one cycle into a strobe, for wait_len cycles
    always @(posedge clk) begin
        act_q <= ~&strobes_n;
        if (~&strobes_n && !act_q) begin
            cnt_q <= wait_len;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    assign wait_n = (cnt_q == 4'h0);
    // Busy stands for a pending write, or for an interrupt need in I/O mode
    assign ready_in = ~busy;
    assign wp_in = wp_sw;
    assign io_read_ack_n = ~(~strobes_n[1] | dma_rq);
    assign {volt_sense_b, volt_sense_a} = volt;
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the card socket control engine
`timescale 1ns/100ps
module tb_top;
    import pcs_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_last = 1'b0;
    logic io_mode = 1'b0;
    logic dma_req_on_wp = 1'b0;
    logic card_reset_req = 1'b0;
    pcs_op_type req_op = PCS_OP_MEM_RD;
    logic [3:0] wait_len = 4'h0;
    logic busy = 1'b0;
    logic wp_sw = 1'b0;
    logic dma_rq = 1'b0;
    logic [1:0] volt = 2'h3;
    logic req_ready, done_pulse, wide_port, write_protected, card_ready, card_irq;
    logic dma_request, oe_n, we_n, io_read_strobe_n, io_write_strobe_n, attr_sel_n, card_reset;
    logic io_acked;
    logic wait_n, ready_in, wp_in, io_read_ack_n, volt_sense_a, volt_sense_b;
    pcs_volt_type card_volt;
    logic [4:0] pins;
    int n_errors = 0;
    int total_checks = 0;
    assign pins = {oe_n, we_n, io_read_strobe_n, io_write_strobe_n, attr_sel_n};
    always #2 clk = ~clk;
    pcs_socket #(.STROBE_CYCLES(8'h04), .RESET_CYCLES(16'h0008)) i_dut (
        .clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_op(req_op),
        .req_last(req_last), .io_mode(io_mode), .dma_req_on_wp(dma_req_on_wp),
        .card_reset_req(card_reset_req), .req_ready(req_ready), .done_pulse(done_pulse),
        .io_acked(io_acked), .wide_port(wide_port), .write_protected(write_protected),
        .card_ready(card_ready), .card_irq(card_irq), .dma_request(dma_request),
        .card_volt(card_volt), .oe_n(oe_n), .we_n(we_n),
        .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
        .attr_sel_n(attr_sel_n), .card_reset(card_reset),
        .wait_n(wait_n), .ready_in(ready_in), .wp_in(wp_in),
        .io_read_ack_n(io_read_ack_n), .volt_sense_a(volt_sense_a),
        .volt_sense_b(volt_sense_b));
    pcs_card_model i_card (
        .clk(clk), .strobes_n(pins[4:1]), .wait_len(wait_len), .busy(busy),
        .wp_sw(wp_sw), .dma_rq(dma_rq), .volt(volt), .wait_n(wait_n),
        .ready_in(ready_in), .wp_in(wp_in), .io_read_ack_n(io_read_ack_n),
        .volt_sense_a(volt_sense_a), .volt_sense_b(volt_sense_b));
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        check(8'h00, 8'h01);
        summarize();
    endtask
    // One host cycle: pattern while strobing, strobe length, completion
    task automatic run(input pcs_op_type op, input logic last, input logic [4:0] exp,
                       input int wl);
        int i;
        int n;
        @(negedge clk);
        for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge clk);
        if (i == 40) hang();
        wait_len = wl[3:0];
        req_op = op;
        req_last = last;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        for (i = 0; i < 40 && pins[4:1] === 4'hF; i++) @(negedge clk);
        if (i == 40) hang();
        check(8'(pins), 8'(exp));
        for (n = 0; n < 60 && pins[4:1] !== 4'hF; n++) @(negedge clk);
        if (wl == 0) check(8'(n), 8'h03);
        else check({7'h0, n > wl}, 8'h01);
        for (i = 0; i < 10 && done_pulse !== 1'b1; i++) @(negedge clk);
        check({7'h0, done_pulse}, 8'h01);
        check(8'(io_acked), 8'(op == PCS_OP_IO_RD));
        @(negedge clk);
        check({3'h0, pins}, 8'h1F);
    endtask
    task automatic t_ops();
        logic [4:0] ex[8] = '{5'h0F, 5'h17, 5'h0E, 5'h16, 5'h1A, 5'h1C, 5'h0A, 5'h14};
        for (int k = 0; k < 8; k++) run(pcs_op_type'(k), k >= 6, ex[k], 0);
        run(PCS_OP_DMA_TO_HOST, 1'b0, 5'h1A, 0);
        run(PCS_OP_DMA_TO_CARD, 1'b0, 5'h1C, 0);
        run(PCS_OP_MEM_WR, 1'b0, 5'h17, 6);
        $display("test cycles done");
    endtask
    task automatic t_status();
        @(negedge clk);
        busy = 1'b1;
        wp_sw = 1'b1;
        dma_req_on_wp = 1'b1;
        repeat (2) @(negedge clk);
        check({5'h0, card_ready, write_protected, dma_request}, 8'h03);
        io_mode = 1'b1;
        repeat (2) @(negedge clk);
        check({6'h0, card_irq, wide_port}, 8'h02);
        busy = 1'b0;
        wp_sw = 1'b0;
        dma_req_on_wp = 1'b0;
        dma_rq = 1'b1;
        repeat (2) @(negedge clk);
        check({5'h0, card_irq, wide_port, dma_request}, 8'h03);
        dma_rq = 1'b0;
        io_mode = 1'b0;
        $display("test status done");
    endtask
    task automatic t_volt();
        logic [1:0] code[4] = '{2'h3, 2'h2, 2'h0, 2'h1};
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            volt = code[k];
            repeat (2) @(negedge clk);
            check({6'h0, card_volt}, 8'(k));
        end
        $display("test sense done");
    endtask
    task automatic t_card_reset();
        int i;
        @(negedge clk);
        card_reset_req = 1'b1;
        @(negedge clk);
        card_reset_req = 1'b0;
        @(negedge clk);
        check({6'h0, card_reset, req_ready}, 8'h02);
        for (i = 0; i < 40 && card_reset !== 1'b0; i++) @(negedge clk);
        check({7'h0, card_reset}, 8'h00);
        check(8'(i), 8'h07);
        run(PCS_OP_MEM_RD, 1'b0, 5'h0F, 0);
        $display("test card reset done");
    endtask
    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        check({1'h0, card_reset, pins, req_ready}, 8'h3F);
        $display("test idle done");
        t_ops();
        t_status();
        t_volt();
        t_card_reset();
        summarize();
    end
endmodule

/* File: verilog/pcs_pkg.sv */
// Package: constants and types for the 16-bit card socket control block
package pcs_pkg;
    // Cycle kinds requested by the host side
    typedef enum logic [2:0] {
        PCS_OP_MEM_RD,
        PCS_OP_MEM_WR,
        PCS_OP_ATTR_RD,
        PCS_OP_ATTR_WR,
        PCS_OP_IO_RD,
        PCS_OP_IO_WR,
        PCS_OP_DMA_TO_HOST,
        PCS_OP_DMA_TO_CARD
    } pcs_op_type;

    // Card voltage class from the two sense lines
    typedef enum logic [1:0] {
        PCS_VOLT_5V,
        PCS_VOLT_3V3,
        PCS_VOLT_LOW,
        PCS_VOLT_NONE
    } pcs_volt_type;

    localparam int STROBE_NS = 100;
    localparam int CLK_NS = 4;
    localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam int RESET_NS = 10000;
    localparam logic [15:0] RESET_CYC = 16'((RESET_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0] SENSE_5V = 2'h3;
    localparam logic [1:0] SENSE_3V3 = 2'h2;
    localparam logic [1:0] SENSE_LOW = 2'h0;
endpackage

/* File: verilog/pcs_socket.sv */
// Module: control-signal engine of one 16-bit card socket
// Contract
// - In DMA the read acknowledge line may carry the card's DMA request.
// - Controller asserts I/O read strobe for host I/O reads.
// - I/O read strobe serves as DMA write strobe, card to host memory.
// - Controller drives I/O write strobe low for host I/O writes.
// - I/O write strobe serves as DMA read strobe, host memory to card.
// - Controller drives output enable low for host memory reads.
// - Output enable signals terminal count in DMA writes, card to host memory.
// - Attribute select stays high for every common memory access.
// - Attribute select low picks attribute memory or I/O space.
// - Attribute select acts as DMA acknowledge together with the I/O strobes.
// - Controller provides a hard reset output to the card.
// - Both voltage sense lines together give the card's voltage.
// - Cycle does not complete while the card holds wait active.
// - Write enable strobes write data into memory cards.
// - Write enable signals terminal count in DMA reads, host memory to card.
`timescale 1ns/100ps
module pcs_socket
    import pcs_pkg::*;
#(
    parameter logic [7:0] STROBE_CYCLES = STROBE_CYC,
    parameter logic [15:0] RESET_CYCLES = RESET_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire pcs_pkg::pcs_op_type req_op,
    input wire logic req_last,
    input wire logic io_mode,
    input wire logic dma_req_on_wp,
    input wire logic card_reset_req,
    output logic req_ready,
    output logic done_pulse,
    output logic io_acked,
    output logic wide_port,
    output logic write_protected,
    output logic card_ready,
    output logic card_irq,
    output logic dma_request,
    output pcs_pkg::pcs_volt_type card_volt,
    output logic oe_n,
    output logic we_n,
    output logic io_read_strobe_n,
    output logic io_write_strobe_n,
    output logic attr_sel_n,
    output logic card_reset,
    input wire logic wait_n,
    input wire logic ready_in,
    input wire logic wp_in,
    input wire logic io_read_ack_n,
    input wire logic volt_sense_a,
    input wire logic volt_sense_b
);
    import pcs_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_END} pcs_state_type;

    pcs_state_type state_q;
    pcs_op_type op_q;
    logic last_q;
    logic strobe_done;
    logic rst_done;
    logic rst_act_q;
    logic ack_seen_q;
    logic is_read;
    logic is_dma;

    assign is_dma = (op_q == PCS_OP_DMA_TO_HOST) || (op_q == PCS_OP_DMA_TO_CARD);
    assign is_read = (op_q == PCS_OP_MEM_RD) || (op_q == PCS_OP_ATTR_RD)
        || (op_q == PCS_OP_IO_RD);

    pcs_stretch #(.WIDTH(8)) u_strobe (
        .clk(clk),
        .arst_n(arst_n),
        .load(state_q == ST_SETUP),
        .count(STROBE_CYCLES),
        .hold(!wait_n),
        .done(strobe_done)
    );

    pcs_stretch #(.WIDTH(16)) u_reset (
        .clk(clk),
        .arst_n(arst_n),
        .load(card_reset_req && !rst_act_q),
        .count(RESET_CYCLES),
        .hold(1'b0),
        .done(rst_done)
    );

    // Cycle sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            op_q <= PCS_OP_MEM_RD;
            last_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (req_valid && !rst_act_q) begin
                        state_q <= ST_SETUP;
                        op_q <= req_op;
                        last_q <= req_last;
                    end
                end
                ST_SETUP: state_q <= ST_STROBE;
                ST_STROBE: begin
                    if (strobe_done) begin
                        state_q <= ST_END;
                    end
                end
                ST_END: state_q <= ST_IDLE;
            endcase
        end
    end

    // Strobe and select pins, idle high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            oe_n <= 1'b1;
            we_n <= 1'b1;
            io_read_strobe_n <= 1'b1;
            io_write_strobe_n <= 1'b1;
            attr_sel_n <= 1'b1;
        end else begin
            oe_n <= 1'b1;
            we_n <= 1'b1;
            io_read_strobe_n <= 1'b1;
            io_write_strobe_n <= 1'b1;
            attr_sel_n <= 1'b1;
            if (state_q == ST_SETUP || state_q == ST_STROBE) begin
                attr_sel_n <= !(op_q == PCS_OP_ATTR_RD || op_q == PCS_OP_ATTR_WR
                    || op_q == PCS_OP_IO_RD || op_q == PCS_OP_IO_WR || is_dma);
            end
            if (state_q == ST_STROBE && !strobe_done) begin
                unique case (op_q)
                    PCS_OP_MEM_RD, PCS_OP_ATTR_RD: oe_n <= 1'b0;
                    PCS_OP_MEM_WR, PCS_OP_ATTR_WR: we_n <= 1'b0;
                    PCS_OP_IO_RD: io_read_strobe_n <= 1'b0;
                    PCS_OP_IO_WR: io_write_strobe_n <= 1'b0;
                    PCS_OP_DMA_TO_HOST: begin
                        io_read_strobe_n <= 1'b0;
                        oe_n <= !last_q;
                    end
                    PCS_OP_DMA_TO_CARD: begin
                        io_write_strobe_n <= 1'b0;
                        we_n <= !last_q;
                    end
                endcase
            end
        end
    end

    // Completion handshake and read acknowledge capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_ready <= 1'b0;
            done_pulse <= 1'b0;
            io_acked <= 1'b0;
            ack_seen_q <= 1'b0;
        end else begin
            req_ready <= state_q == ST_IDLE && !rst_act_q && !req_valid;
            done_pulse <= state_q == ST_END;
            if (state_q == ST_SETUP) begin
                ack_seen_q <= 1'b0;
            end else if (state_q == ST_STROBE && !io_read_ack_n && op_q == PCS_OP_IO_RD) begin
                ack_seen_q <= 1'b1;
            end
            if (state_q == ST_END) begin
                io_acked <= ack_seen_q && is_read;
            end
        end
    end

    // Card reset pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_act_q <= 1'b0;
            card_reset <= 1'b0;
        end else begin
            if (card_reset_req && !rst_act_q) begin
                rst_act_q <= 1'b1;
                card_reset <= 1'b1;
            end else if (rst_done) begin
                rst_act_q <= 1'b0;
                card_reset <= 1'b0;
            end
        end
    end

    // Status inputs toward the host
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wide_port <= 1'b0;
            write_protected <= 1'b0;
            card_ready <= 1'b0;
            card_irq <= 1'b0;
            dma_request <= 1'b0;
            card_volt <= PCS_VOLT_NONE;
        end else begin
            write_protected <= !io_mode && wp_in;
            wide_port <= io_mode && !wp_in;
            card_ready <= !io_mode && ready_in;
            card_irq <= io_mode && !ready_in;
            dma_request <= dma_req_on_wp ? wp_in : !io_read_ack_n;
            unique case ({volt_sense_b, volt_sense_a})
                SENSE_5V: card_volt <= PCS_VOLT_5V;
                SENSE_3V3: card_volt <= PCS_VOLT_3V3;
                SENSE_LOW: card_volt <= PCS_VOLT_LOW;
                default: card_volt <= PCS_VOLT_NONE;
            endcase
        end
    end

    strobe_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_IDLE |=> oe_n && we_n && io_read_strobe_n && io_write_strobe_n)
        else $error("strobe active while idle");
    attr_common_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == ST_STROBE && op_q == PCS_OP_MEM_RD) |=> attr_sel_n)
        else $error("attribute select low on common access");
    wait_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == ST_STROBE && !wait_n) |=> state_q == ST_STROBE)
        else $error("cycle ended under wait");
    io_rd_strobe_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == ST_STROBE && op_q == PCS_OP_IO_RD && !strobe_done)
        |=> !io_read_strobe_n && !attr_sel_n)
        else $error("io read strobe missing");
    io_wr_strobe_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == ST_STROBE && op_q == PCS_OP_IO_WR && !strobe_done)
        |=> !io_write_strobe_n)
        else $error("io write strobe missing");
    mem_rd_oe_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == ST_STROBE && op_q == PCS_OP_MEM_RD && !strobe_done) |=> !oe_n)
        else $error("output enable missing");
    dma_host_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == ST_STROBE && op_q == PCS_OP_DMA_TO_HOST && !strobe_done)
        |=> !io_read_strobe_n && (oe_n == !last_q))
        else $error("dma to host strobes wrong");
    dma_card_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == ST_STROBE && op_q == PCS_OP_DMA_TO_CARD && !strobe_done)
        |=> !io_write_strobe_n && (we_n == !last_q) && !attr_sel_n)
        else $error("dma to card strobes wrong");
    reset_out_a: assert property (@(posedge clk) disable iff (!arst_n)
        (card_reset_req && !rst_act_q) |=> card_reset ##1 card_reset)
        else $error("card reset not driven");
    irq_map_a: assert property (@(posedge clk) disable iff (!arst_n)
        (io_mode && !ready_in) |=> card_irq && !card_ready)
        else $error("interrupt mapping wrong");

    io_read_c: cover property (@(posedge clk) state_q == ST_END && op_q == PCS_OP_IO_RD);
    wait_c: cover property (@(posedge clk) state_q == ST_STROBE && !wait_n);
    dma_last_c: cover property (@(posedge clk) state_q == ST_END && is_dma && last_q);
endmodule

/* File: verilog/pcs_stretch.sv */
// Module: loadable down-counter that times a strobe or a reset pulse
`timescale 1ns/100ps
module pcs_stretch #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    input wire logic hold,
    output logic done
);
    logic [WIDTH-1:0] cnt_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q > WIDTH'(1) || (cnt_q == WIDTH'(1) && !hold)) begin
            cnt_q <= cnt_q - WIDTH'(1);
        end
    end

    assign done = (cnt_q == WIDTH'(1)) && !hold;
endmodule
